// ===== dv/sas_arp_identity_assertions.sv
// port-level assertions for the strap decode and identity block
`timescale 1ns/1ps

module sas_arp_identity_chk (
  input wire        pclk,                    // device clock
  input wire        presetn,                 // async reset, low
  input wire        psel,                    // apb select
  input wire        penable,                 // apb enable
  input wire        pready,                  // apb ready
  input wire        pslverr,                 // apb error
  input wire        rx_valid,                // byte strobe in
  input wire [7:0]  rx_data,                 // byte in
  input wire        tx_req,                  // byte request
  input wire        bus_ack,                 // ack decision
  input wire [7:0]  addr_ptr,                // address pointer
  input wire        reg_wr_valid,            // data write pulse
  input wire [7:0]  reg_wr_data,             // data written
  input wire        fixed_discoverable_mode, // fixed mode
  input wire [2:0]  position_bits,           // strap position
  input wire [6:0]  slave_addr               // slave address
);
  // ==========================================================
  // cycles since reset; saturates so late checks stay enabled
  reg [7:0] cyc_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cyc_reg <= 8'h00;
    else if (cyc_reg != 8'hFF)
      cyc_reg <= cyc_reg + 8'h01;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // apb setup cycle, then its answer
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    s_setup ##1 pready;
  endsequence

  // ==========================================================
  // properties
  chk_zero_wait: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  chk_ready_once: assert property (s_access |=> !pready)
    else $error("pready held past access");
  chk_err_ready: assert property (pslverr |-> pready && penable)
    else $error("pslverr outside access");
  chk_strap_early: assert property (
    cyc_reg < 8'h64 |-> position_bits == 3'h0 && slave_addr == 7'h00)
    else $error("strap outputs set before capture");
  chk_strap_hold: assert property (
    cyc_reg > 8'h82 |-> $stable(position_bits)
      && $stable(fixed_discoverable_mode))
    else $error("strap result changed after capture");
  chk_mode_pos: assert property (
    cyc_reg > 8'h82 |-> (fixed_discoverable_mode ?
      position_bits == 3'h0 : position_bits[2]))
    else $error("mode and position disagree");
  chk_fixed_addr: assert property (
    fixed_discoverable_mode && $past(fixed_discoverable_mode)
      |-> slave_addr[6:2] == 5'h14 && $stable(slave_addr))
    else $error("fixed address moved or out of range");
  chk_link_hold: assert property (
    !rx_valid && !tx_req |=> $stable(bus_ack))
    else $error("ack changed without a strobe");
  chk_ptr_load: assert property (!rx_valid |=> $stable(addr_ptr))
    else $error("pointer changed without a byte");
  chk_wr_data: assert property (
    reg_wr_valid |-> $past(rx_valid) && reg_wr_data == $past(rx_data))
    else $error("written byte differs from received byte");
endmodule

bind sas_arp_identity sas_arp_identity_chk chk_inst (.*);

// ===== dv/sas_arp_identity_tb.sv
// self-checking bench for the strap decode and identity block
`timescale 1ns/1ps
`include "sas_regs.vh"

module sas_arp_identity_tb;
  localparam [7:0]  VR  = 8'h08;    // arbitrary value
  localparam [15:0] VID = 16'h5A5A; // arbitrary value
  localparam [15:0] DID = 16'hA5C3; // arbitrary value
  reg          pclk, presetn, psel, penable, pwrite, e;
  reg  [11:0]  paddr;
  reg  [31:0]  pwdata, q;
  reg  [2:0]   strap;
  reg  [127:0] u;
  reg  [7:0]   pc, rd_byte;
  wire [31:0]  prdata;
  wire         pready, pslverr, bus_start, bus_stop, rx_valid, tx_req;
  wire         bus_ack, reg_wr_valid, fixed_discoverable_mode;
  wire [7:0]   rx_data, tx_data, addr_ptr, reg_wr_data;
  wire [2:0]   position_bits;
  wire [6:0]   slave_addr;
  integer      bad_count, n_compared, i, k;

  sas_arp_identity #(.VER_REV(VR), .VENDOR_ID(VID), .DEVICE_ID(DID))
  sas_arp_identity_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .board_position_strap(strap),
    .bus_start(bus_start), .bus_stop(bus_stop), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_req(tx_req), .reg_rd_data(rd_byte),
    .bus_ack(bus_ack), .tx_data(tx_data), .addr_ptr(addr_ptr),
    .reg_wr_valid(reg_wr_valid), .reg_wr_data(reg_wr_data),
    .fixed_discoverable_mode(fixed_discoverable_mode),
    .position_bits(position_bits), .slave_addr(slave_addr));
  sas_smbus_host host_inst (
    .pclk(pclk), .bus_ack(bus_ack), .tx_data(tx_data),
    .bus_start(bus_start), .bus_stop(bus_stop), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_req(tx_req));

  // 125 mhz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ==========================================================
  // shared tasks
  task stop_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task cmp(input [63:0] nm, input [31:0] x, input [31:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== x) begin
        bad_count = bad_count + 1;
        $display("FAIL %0s exp %h got %h", nm, x, g);
      end
    end
  endtask

  // apb transfer; the wait for pready is bounded
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (pready !== 1'b1) begin
        cmp("pready", 32'h1, 32'h0);
        stop_test;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // new power-up with a given strap level
  task pwr(input [2:0] s);
    begin
      presetn <= 1'b0;
      strap <= s;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
    end
  endtask

  // expected identifier from rules plus the captured random field
  task mkid(input [2:0] p);
    begin
      apb(1'b0, `SAS_OFF_RAND, 32'h0);
      u = {8'hC1, VR, VID, DID, 16'h0004, 32'h0, 13'h0, p, q[15:0]};
      for (k = 0; k < 4; k = k + 1) begin
        apb(1'b0, `SAS_OFF_UDID3 + 12'(4 * k), 32'h0);
        cmp("udid", u[127 - 32 * k -: 32], q);
      end
    end
  endtask

  task getu(input [7:0] c, input [7:0] last);
    begin
      host_inst.frm(1'b1);
      host_inst.sb(8'hC2);
      host_inst.sb(c);
      host_inst.frm(1'b1);
      host_inst.sb(8'hC3);
      host_inst.gb;
      cmp("count", 32'h11, {24'h0, host_inst.got});
      for (k = 15; k >= 0; k = k - 1) begin
        host_inst.gb;
        cmp("udidb", {24'h0, u[8 * k +: 8]}, {24'h0, host_inst.got});
      end
      host_inst.gb;
      cmp("addrb", {24'h0, last}, {24'h0, host_inst.got});
      pc = host_inst.crc;
      host_inst.gb;
      cmp("pec", {24'h0, pc}, {24'h0, host_inst.got});
      host_inst.frm(1'b0);
    end
  endtask

  // three-byte command with a good or spoiled pec
  task cmd(input [7:0] c, input bad);
    begin
      host_inst.frm(1'b1);
      host_inst.sb(8'hC2);
      host_inst.sb(c);
      host_inst.sb(host_inst.crc ^ {8{bad}});
      cmp("cmdack", {31'h0, !bad}, {31'h0, host_inst.ack});
      host_inst.frm(1'b0);
    end
  endtask

  task asg(input [6:0] na);
    begin
      host_inst.frm(1'b1);
      host_inst.sb(8'hC2);
      host_inst.sb(8'h04);
      host_inst.sb(8'h11);
      for (k = 15; k >= 0; k = k - 1)
        host_inst.sb(u[8 * k +: 8]);
      host_inst.sb({na, 1'b0});
      host_inst.sb(host_inst.crc);
      cmp("asgack", 32'h1, {31'h0, host_inst.ack});
      host_inst.frm(1'b0);
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    bad_count = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    strap = 3'h5;
    rd_byte = 8'hA7;
    pwr(3'h5);
    apb(1'b0, `SAS_OFF_STATUS, 32'h0);
    cmp("done", 32'h0, {31'h0, q[4]});
    apb(1'b0, `SAS_OFF_CTRL, 32'h0);
    cmp("ctrl", 32'h1, q);
    apb(1'b0, 12'h01C, 32'h0);
    cmp("slverr", 32'h1, {31'h0, e});
    apb(1'b1, `SAS_OFF_CTRL, 32'h0);
    repeat (130) @(posedge pclk);
    host_inst.frm(1'b1);
    host_inst.sb(8'hC2);
    cmp("arpoff", 32'h0, {31'h0, host_inst.ack});
    host_inst.frm(1'b0);
    $display("test registers done");
    for (i = 0; i < 8; i = i + 1) begin
      pwr(i[2:0]);
      repeat (130) @(posedge pclk);
      strap <= ~strap; // late strap moves must not matter
      repeat (20) @(posedge pclk);
      apb(1'b0, `SAS_OFF_STATUS, 32'h0);
      cmp("mode", (i < 4) ? 32'h8 : 32'(i), {28'h0, q[3:0]});
      cmp("fixaddr", (i < 4) ? 32'h50 + 32'(i) : 32'h0, {25'h0, q[14:8]});
    end
    $display("test strap levels done");
    pwr(3'h5);
    repeat (130) @(posedge pclk);
    mkid(3'h5);
    getu(8'h03, 8'hFF);
    cmd(8'h01, 1'b1);
    cmd(8'h01, 1'b0);
    asg(7'h3A);
    cmp("newaddr", 32'h3A, {25'h0, slave_addr});
    getu(8'h75, 8'h75);
    host_inst.frm(1'b1);
    host_inst.sb(8'h74);
    host_inst.sb(8'h25);
    cmp("ptr", 32'h25, {24'h0, addr_ptr});
    host_inst.sb(8'h7E);
    cmp("wrdata", 32'h7E, {24'h0, reg_wr_data});
    host_inst.frm(1'b1);
    rd_byte <= 8'h5C;
    host_inst.sb(8'h75);
    host_inst.gb;
    cmp("rddata", {24'h0, rd_byte}, {24'h0, host_inst.got});
    host_inst.frm(1'b0);
    apb(1'b0, `SAS_OFF_RAND, 32'h0);
    cmp("rand", {16'h0, u[15:0]}, {16'h0, q[15:0]});
    cmd(8'h74, 1'b0);
    apb(1'b0, `SAS_OFF_STATUS, 32'h0);
    cmp("av", 32'h0, {31'h0, q[6]});
    cmd(8'h02, 1'b0);
    $display("test arp mode done");
    pwr(3'h2);
    repeat (130) @(posedge pclk);
    mkid(3'h0);
    asg(7'h3A);
    cmp("keep", 32'h52, {25'h0, slave_addr});
    $display("test fixed mode done");
    stop_test;
  end
endmodule

// ===== dv/sas_smbus_host.sv
// smbus host model driving the byte link of the identity block
`timescale 1ns/1ps

module sas_smbus_host (
  input  wire       pclk,      // device clock
  input  wire       bus_ack,   // ack from device
  input  wire [7:0] tx_data,   // byte from device
  output reg        bus_start, // start pulse
  output reg        bus_stop,  // stop pulse
  output reg        rx_valid,  // byte strobe
  output reg  [7:0] rx_data,   // byte to device
  output reg        tx_req     // read request
);
  reg [7:0] crc; // running pec, kept across repeated start
  reg       ack; // last ack seen
  reg [7:0] got; // last byte read

  // idle link at time zero
  initial begin
    bus_start = 1'b0;
    bus_stop = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_req = 1'b0;
    crc = 8'h00;
  end

  // ==========================================================
  // pec folds every byte in both directions
  function [7:0] c8(input [7:0] c, input [7:0] d);
    integer i;
    reg [7:0] x;
    begin
      x = c ^ d;
      for (i = 0; i < 8; i = i + 1)
        x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
      c8 = x;
    end
  endfunction

  // framing pulse: 1 start, 0 stop; stop begins a fresh pec
  task frm(input s);
    begin
      @(posedge pclk);
      bus_start <= s;
      bus_stop <= !s;
      @(posedge pclk);
      bus_start <= 1'b0;
      bus_stop <= 1'b0;
      if (!s)
        crc = 8'h00;
    end
  endtask

  // caller picks general or directed address bytes
  task sb(input [7:0] b);
    begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= b;
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_data <= ~b; // released line never shows the old byte
      crc = c8(crc, b);
      @(negedge pclk);
      ack = bus_ack;
    end
  endtask

  // request one byte from the device
  task gb;
    begin
      @(posedge pclk);
      tx_req <= 1'b1;
      @(posedge pclk);
      tx_req <= 1'b0;
      @(negedge pclk);
      got = tx_data;
      crc = c8(crc, got);
    end
  endtask
endmodule

// ===== inc/sas_regs.vh
// constants for the strap decode and address resolution identity block
`ifndef SAS_REGS_VH
`define SAS_REGS_VH

// ==========================================================
// clock and timing
`define SAS_CLK_PERIOD_NS    8
`define SAS_STRAP_SETTLE_NS  1000
`define SAS_STRAP_SETTLE_CYC 8'h7D

// ==========================================================
// register offsets (byte addresses)
`define SAS_OFF_STATUS 12'h000
`define SAS_OFF_CTRL   12'h004
`define SAS_OFF_UDID3  12'h008
`define SAS_OFF_UDID2  12'h00C
`define SAS_OFF_UDID1  12'h010
`define SAS_OFF_UDID0  12'h014
`define SAS_OFF_RAND   12'h018

// ==========================================================
// fields and reset values
`define SAS_CTRL_RESET   1'b1
`define SAS_CTRL_ARP_EN  0
`define SAS_ST_POS_LSB   0
`define SAS_ST_FIXED     3
`define SAS_ST_DONE      4
`define SAS_ST_AR        5
`define SAS_ST_AV        6
`define SAS_ST_ADDR_LSB  8
`define SAS_ST_PTR_LSB   16

// ==========================================================
// protocol constants
`define SAS_ARP_ADDR        7'h61
`define SAS_FIXED_ADDR_BASE 7'h50
`define SAS_CAP_BYTE        8'hC1
`define SAS_IFACE_FIELD     16'h0004
`define SAS_UDID_COUNT      8'h11
`define SAS_CMD_PREPARE     8'h01
`define SAS_CMD_RESET       8'h02
`define SAS_CMD_GET_UDID    8'h03
`define SAS_CMD_ASSIGN      8'h04
`define SAS_NO_ADDR_BYTE    8'hFF
`define SAS_IDX_COUNT       5'h01
`define SAS_IDX_UDID_LAST   5'h11
`define SAS_IDX_NEW_ADDR    5'h12
`define SAS_IDX_ASSIGN_PEC  5'h13
`define SAS_TX_ADDR_IDX     5'h11
`define SAS_TX_PEC_IDX      5'h12
`define SAS_CRC_POLY        8'h07
`define SAS_LFSR_SEED       16'hACE1
`define SAS_LFSR_TAPS       16'hB400

`endif

// ===== logic/sas_arp_identity.v
// strap decode, unique identifier and address resolution engine
//
// Summary of operation
// - strap sampled once after power-up only
// - strap resolved into three-bit level code
// - top four levels select arp mode
// - low four levels give fixed addresses
// - arp mode allows dynamic address assignment
// - identifier is 128 bits, read on request
// - random field comes from internal lfsr
// - position bits placed into identifier
// - low word: zeros, position, random
// - top byte is capabilities 11000001
// - version one plus revision byte
// - vendor and device codes are constants
// - interface field holds value four
// - subsystem fields read all zero
// - general and directed commands both accepted
// - prepare, reset and assign carry checked pec; get returns a pec
// - prepare, assign general; reset, get both
// - first write byte loads address pointer
// - fixed mode ignores assigned address
`timescale 1ns/1ps
`include "sas_regs.vh"

module sas_arp_identity #(
  parameter [7:0]  VER_REV   = 8'h08,  // version one; revision arbitrary
  parameter [15:0] VENDOR_ID = 16'h5A5A, // arbitrary value
  parameter [15:0] DEVICE_ID = 16'hA5C3  // arbitrary value
) (
  input  wire        pclk,                     // device clock
  input  wire        presetn,                  // async reset, low
  input  wire        psel,                     // apb select
  input  wire        penable,                  // apb enable
  input  wire        pwrite,                   // apb direction
  input  wire [11:0] paddr,                    // apb byte address
  input  wire [31:0] pwdata,                   // apb write data
  output reg  [31:0] prdata,                   // apb read data
  output reg         pready,                   // apb ready
  output reg         pslverr,                  // apb error
  input  wire [2:0]  board_position_strap,     // converter level code
  input  wire        bus_start,                // start or repeated start
  input  wire        bus_stop,                 // stop seen
  input  wire        rx_valid,                 // received byte strobe
  input  wire [7:0]  rx_data,                  // received byte
  input  wire        tx_req,                   // framer wants a byte
  input  wire [7:0]  reg_rd_data,              // register byte for reads
  output reg         bus_ack,                  // ack for last byte
  output reg  [7:0]  tx_data,                  // byte to transmit
  output reg  [7:0]  addr_ptr,                 // register address pointer
  output reg         reg_wr_valid,             // data byte write pulse
  output reg  [7:0]  reg_wr_data,              // data byte written
  output reg         fixed_discoverable_mode,  // strap chose fixed mode
  output reg  [2:0]  position_bits,            // position in identifier
  output reg  [6:0]  slave_addr                // current slave address
);

  // ==========================================================
  // states of the byte engine
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_ARPW = 3'h2;
  localparam [2:0] S_DEVW = 3'h3;
  localparam [2:0] S_ARPR = 3'h4;
  localparam [2:0] S_DEVR = 3'h5;
  localparam [2:0] S_SKIP = 3'h6;
  localparam [7:0] SETTLE = `SAS_STRAP_SETTLE_CYC;

  reg  [2:0]   strap_s1_reg;
  reg  [2:0]   strap_s2_reg;
  reg  [7:0]   settle_cnt_reg;
  reg          strap_done_reg;
  reg  [15:0]  rand_reg;
  reg          ar_reg;
  reg          av_reg;
  reg  [2:0]   st_reg;
  reg  [4:0]   bcnt_reg;
  reg  [4:0]   tx_idx_reg;
  reg  [7:0]   cmd_reg;
  reg          udid_pend_reg;
  reg          match_reg;
  reg  [6:0]   new_addr_reg;
  reg  [7:0]   pec_reg;
  reg          ctrl_arp_en_reg;
  reg  [7:0]   tx_byte;
  reg  [31:0]  rd_mux;
  reg          rd_hit;
  wire [15:0]  lfsr_value;
  wire [7:0]   crc_next;
  wire [127:0] udid;
  wire [127:0] udid_sh;
  wire [4:0]   rx_ub;
  wire [4:0]   tx_ub;
  wire [3:0]   ub_sel;
  wire [7:0]   ubyte;
  wire         arp_ok;
  wire         addr_arp;
  wire         addr_own;
  wire         cmd_is_reset;
  wire         pec_ok;
  wire         apb_setup;
  wire         apb_write;
  sas_lfsr16 u_lfsr (
    .clk   (pclk),
    .rst_n (presetn),
    .value (lfsr_value)
  );

  // the framer never strobes rx and tx together, so one crc suffices
  sas_crc8 u_crc (
    .crc_in  (pec_reg),
    .data_in (rx_valid ? rx_data : tx_byte),
    .crc_out (crc_next)
  );

  // ==========================================================
  // identifier assembly
  // full 128-bit identifier
  assign udid = {`SAS_CAP_BYTE, VER_REV, VENDOR_ID, DEVICE_ID,
                 `SAS_IFACE_FIELD, 32'h00000000, 13'h0000,
                 position_bits, rand_reg};

  // byte select, msb first; rx counts from the command byte, tx from 1
  assign rx_ub   = bcnt_reg - 5'h02;
  assign tx_ub   = tx_idx_reg - 5'h01;
  assign ub_sel  = (st_reg == S_ARPR) ? tx_ub[3:0] : rx_ub[3:0];
  assign udid_sh = udid << {ub_sel, 3'b000};
  assign ubyte   = udid_sh[127:120];

  assign arp_ok       = ctrl_arp_en_reg & strap_done_reg;
  assign addr_arp     = arp_ok && (rx_data[7:1] == `SAS_ARP_ADDR);
  assign addr_own     = av_reg && (rx_data[7:1] == slave_addr);
  assign cmd_is_reset = (cmd_reg == `SAS_CMD_RESET) ||
                        (av_reg && (cmd_reg == {slave_addr, 1'b0}));
  assign pec_ok       = (rx_data == pec_reg);

  // ==========================================================
  // transmit byte for a get-identifier or device register read
  always @* begin
    tx_byte = `SAS_NO_ADDR_BYTE;
    if (st_reg == S_ARPR) begin
      if (tx_idx_reg == 5'h00)
        tx_byte = `SAS_UDID_COUNT;
      else if (tx_idx_reg <= `SAS_IDX_UDID_LAST - 5'h01)
        tx_byte = ubyte;
      else if (tx_idx_reg == `SAS_TX_ADDR_IDX)
        tx_byte = av_reg ? {slave_addr, 1'b1} : `SAS_NO_ADDR_BYTE;
      else if (tx_idx_reg == `SAS_TX_PEC_IDX)
        tx_byte = pec_reg;
    end else if (st_reg == S_DEVR)
      tx_byte = reg_rd_data;
  end

  // ==========================================================
  // strap capture and byte engine; one process so each flag has one owner
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_reg            <= 3'h0;
      strap_s2_reg            <= 3'h0;
      settle_cnt_reg          <= 8'h00;
      strap_done_reg          <= 1'b0;
      rand_reg                <= 16'h0000;
      fixed_discoverable_mode <= 1'b0;
      position_bits           <= 3'h0;
      slave_addr              <= 7'h00;
      ar_reg                  <= 1'b0;
      av_reg                  <= 1'b0;
      st_reg                  <= S_IDLE;
      bcnt_reg                <= 5'h00;
      tx_idx_reg              <= 5'h00;
      cmd_reg                 <= 8'h00;
      udid_pend_reg           <= 1'b0;
      match_reg               <= 1'b0;
      new_addr_reg            <= 7'h00;
      pec_reg                 <= 8'h00;
      bus_ack                 <= 1'b0;
      tx_data                 <= 8'h00;
      addr_ptr                <= 8'h00;
      reg_wr_valid            <= 1'b0;
      reg_wr_data             <= 8'h00;
    end else begin
      // converter code is asynchronous to pclk
      strap_s1_reg <= board_position_strap;
      strap_s2_reg <= strap_s1_reg;
      reg_wr_valid <= 1'b0;
      if (!strap_done_reg) begin
        if (settle_cnt_reg == SETTLE - 8'h01) begin
          strap_done_reg <= 1'b1;
          rand_reg <= lfsr_value;
          fixed_discoverable_mode <= ~strap_s2_reg[2];
          position_bits <= strap_s2_reg[2] ? strap_s2_reg : 3'h0;
          if (!strap_s2_reg[2]) begin
            slave_addr <= `SAS_FIXED_ADDR_BASE | {5'h00, strap_s2_reg[1:0]};
            av_reg     <= 1'b1;
          end
        end else
          settle_cnt_reg <= settle_cnt_reg + 8'h01;
      end
      if (bus_stop) begin
        st_reg        <= S_IDLE;
        udid_pend_reg <= 1'b0;
      end else if (bus_start) begin
        st_reg     <= S_ADDR;
        bcnt_reg   <= 5'h00;
        tx_idx_reg <= 5'h00;
        // pec spans the repeated start of a get-identifier read
        if (!udid_pend_reg)
          pec_reg <= 8'h00;
      end else if (rx_valid) begin
        pec_reg <= crc_next;
        if (bcnt_reg != 5'h1F)
          bcnt_reg <= bcnt_reg + 5'h01;
        case (st_reg)
          S_ADDR: begin
            bcnt_reg <= 5'h00;
            if (addr_arp && !rx_data[0]) begin
              st_reg  <= S_ARPW;
              bus_ack <= 1'b1;
            end else if (addr_arp && udid_pend_reg) begin
              st_reg  <= S_ARPR;
              bus_ack <= 1'b1;
            end else if (addr_own) begin
              st_reg  <= rx_data[0] ? S_DEVR : S_DEVW;
              bus_ack <= 1'b1;
            end else begin
              st_reg  <= S_SKIP;
              bus_ack <= 1'b0;
            end
          end
          S_ARPW: begin
            if (bcnt_reg == 5'h00) begin
              cmd_reg   <= rx_data;
              match_reg <= 1'b1;
              if (rx_data == `SAS_CMD_PREPARE ||
                  rx_data == `SAS_CMD_RESET ||
                  rx_data == `SAS_CMD_ASSIGN ||
                  (av_reg && rx_data == {slave_addr, 1'b0})) begin
                bus_ack <= 1'b1;
              end else if ((rx_data == `SAS_CMD_GET_UDID && !ar_reg) ||
                           (av_reg && rx_data == {slave_addr, 1'b1})) begin
                bus_ack       <= 1'b1;
                udid_pend_reg <= 1'b1;
              end else begin
                bus_ack <= 1'b0;
                st_reg  <= S_SKIP;
              end
            end else if (cmd_reg == `SAS_CMD_ASSIGN) begin
              if (bcnt_reg == `SAS_IDX_COUNT) begin
                bus_ack <= (rx_data == `SAS_UDID_COUNT);
                if (rx_data != `SAS_UDID_COUNT)
                  st_reg <= S_SKIP;
              end else if (bcnt_reg <= `SAS_IDX_UDID_LAST) begin
                bus_ack   <= 1'b1;
                match_reg <= match_reg & (rx_data == ubyte);
              end else if (bcnt_reg == `SAS_IDX_NEW_ADDR) begin
                bus_ack      <= 1'b1;
                new_addr_reg <= rx_data[7:1];
              end else if (bcnt_reg == `SAS_IDX_ASSIGN_PEC) begin
                // assign acts only on good pec
                bus_ack <= pec_ok;
                if (pec_ok && match_reg) begin
                  ar_reg <= 1'b1;
                  av_reg <= 1'b1;
                  if (!fixed_discoverable_mode)
                    slave_addr <= new_addr_reg;
                end
              end else begin
                bus_ack <= 1'b0;
                st_reg  <= S_SKIP;
              end
            end else if (bcnt_reg == `SAS_IDX_COUNT &&
                         (cmd_reg == `SAS_CMD_PREPARE || cmd_is_reset)) begin
              bus_ack <= pec_ok;
              if (pec_ok) begin
                ar_reg <= 1'b0;
                if (cmd_is_reset && !fixed_discoverable_mode)
                  av_reg <= 1'b0;
              end
            end else begin
              bus_ack <= 1'b0;
              st_reg  <= S_SKIP;
            end
          end
          S_DEVW: begin
            bus_ack <= 1'b1;
            if (bcnt_reg == 5'h00)
              addr_ptr <= rx_data;
            else begin
              reg_wr_valid <= 1'b1;
              reg_wr_data  <= rx_data;
            end
          end
          default: bus_ack <= 1'b0;
        endcase
      end else if (tx_req) begin
        tx_data <= tx_byte;
        if (st_reg == S_ARPR) begin
          pec_reg <= crc_next;
          if (tx_idx_reg != 5'h1F)
            tx_idx_reg <= tx_idx_reg + 5'h01;
        end
      end
    end
  end

  // ==========================================================
  // apb read mux
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      `SAS_OFF_STATUS: rd_mux = {8'h00, addr_ptr, 1'b0, slave_addr,
                                 1'b0, av_reg, ar_reg, strap_done_reg,
                                 fixed_discoverable_mode, position_bits};
      `SAS_OFF_CTRL:   rd_mux = {31'h00000000, ctrl_arp_en_reg};
      `SAS_OFF_UDID3:  rd_mux = udid[127:96];
      `SAS_OFF_UDID2:  rd_mux = udid[95:64];
      `SAS_OFF_UDID1:  rd_mux = udid[63:32];
      `SAS_OFF_UDID0:  rd_mux = udid[31:0];
      `SAS_OFF_RAND:   rd_mux = {16'h0000, rand_reg};
      default:         rd_hit = 1'b0;
    endcase
  end

  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;

  // ==========================================================
  // zero-wait apb slave; read data caught at setup stays through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      prdata          <= 32'h00000000;
      ctrl_arp_en_reg <= `SAS_CTRL_RESET;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~rd_hit;
      if (apb_setup && !pwrite)
        prdata <= rd_mux;
      if (apb_write && paddr == `SAS_OFF_CTRL)
        ctrl_arp_en_reg <= pwdata[`SAS_CTRL_ARP_EN];
    end
  end

endmodule

// ===== logic/sas_crc8.v
// byte-wide crc-8 step used for packet error checking
`timescale 1ns/1ps
`include "sas_regs.vh"

module sas_crc8 (
  input  wire [7:0] crc_in,   // running crc
  input  wire [7:0] data_in,  // byte to fold in
  output reg  [7:0] crc_out   // updated crc
);

  reg [7:0] c;
  integer   i;

  // ==========================================================
  // msb first, polynomial x^8+x^2+x+1
  always @* begin
    c = crc_in ^ data_in;
    for (i = 0; i < 8; i = i + 1) begin
      c = c[7] ? ((c << 1) ^ `SAS_CRC_POLY) : (c << 1);
    end
    crc_out = c;
  end

endmodule

// ===== logic/sas_lfsr16.v
// free-running 16-bit lfsr feeding the random identifier field
`timescale 1ns/1ps
`include "sas_regs.vh"

module sas_lfsr16 (
  input  wire        clk,    // device clock
  input  wire        rst_n,  // async reset, active low
  output reg  [15:0] value   // current lfsr state
);

  // ==========================================================
  // galois form; seed is nonzero so it never locks up
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= `SAS_LFSR_SEED;
    end else begin
      value <= value[0] ? ((value >> 1) ^ `SAS_LFSR_TAPS) : (value >> 1);
    end
  end

endmodule
